/* File: verilog/t1_sync_map.svh */
/*
 * register indices, field positions, reset values and timing counts of the
 * receive frame synchroniser control block.
 * assumes a 25 mhz system clock; byte address = 4 * register index.
 */
`ifndef T1_SYNC_MAP_SVH
`define T1_SYNC_MAP_SVH

// ****************************************************************
// register indices
// ****************************************************************
`define IDX_PULSE_FLAGS 8'h4b
`define IDX_PULSE_EN 8'h4c
`define IDX_MODE_A 8'h4d
`define IDX_MODE_B 8'h4e
`define IDX_SYNC_STATE 8'h4f
`define IDX_IRQ_EN_A 8'h50
`define IDX_IRQ_EN_B 8'h51
`define IDX_FLAGS_A 8'h52
`define IDX_FLAGS_B 8'h53
`define IDX_FORMAT 8'h55

// ****************************************************************
// field positions
// ****************************************************************
`define B_TX_PULSE 0
`define B_RX_PULSE 1
`define B_FORCE_REFRAME 0
`define B_AUTO_REFRAME 1
`define B_CRC_REFRAME 2
`define B_UNFRAMED 3
`define B_LOSS_LO 0
`define B_LOSS_HI 1
`define B_MIMIC_CRIT 2
`define B_DDS_CRIT 3
`define B_OOS 0
`define B_SYNC_CHANGE 0
`define B_MIMIC_SEEN 4
`define B_CRC_EXCESS 5
`define B_FMT_LO 0
`define B_FMT_HI 1
`define B_SLC_FS 2

// ****************************************************************
// reset values and format codes
// ****************************************************************
`define RST_MODE_A 8'h06
`define RST_ZERO 8'h00
`define FMT_SF 2'h0
`define FMT_ESF 2'h1
`define FMT_T1DM 2'h2
`define FMT_SLC 2'h3

// ****************************************************************
// counts and timing
// ****************************************************************
`define CLOCK_PERIOD_NS 40
`define CRC_WINDOW_NS 1000000000
`define PULSE_GRID_NS 125000
`define CRC_EXCESS_LIMIT 9'h13f
`define SF_GOOD_NEEDED 3'h2
`define ESF_GOOD_NEEDED 3'h4
`define LOSS_ERRS 3'h2
`define WIN_4 3'h4
`define WIN_5 3'h5
`define WIN_6 3'h6

`endif

/* File: verilog/t1_sync_pkg.sv */
/*
 * types of the receive frame synchroniser control block.
 * assumes t1_sync_map.svh for the numeric codes.
 */
`default_nettype none
`include "t1_sync_map.svh"

package t1_sync_pkg;

	// sync state machine, one-hot
	typedef enum logic [1:0] {
		ST_SEARCH = 2'b01,
		ST_INSYNC = 2'b10
	} sync_state_t;

	// events from the framing bit comparator, one cycle each
	typedef struct packed {
		logic ft_valid; // framing bit / pattern unit evaluated
		logic ft_err; // that unit mismatched
		logic fs_valid; // slc-96 qualifying fs bit evaluated
		logic fs_err; // that fs bit mismatched
		logic pattern_done; // one full alignment pattern evaluated
		logic pattern_ok; // it was error free
		logic crc_ok; // correct crc-6 in the same frame
		logic crc_err; // crc-6 error event
		logic mimic; // mimic pattern present
		logic dds_first_ok; // dds correct before first f-bit
		logic dds_all_ok; // dds correct before all twelve f-bits
		logic mf_start; // first bit of a multiframe
		logic severe_err; // severe framing error event
		logic align_move; // new f-bit position differs
	} frame_ev_t;

	// every flip-flop of the block
	typedef struct packed {
		sync_state_t st;
		logic [7:0] mode_a;
		logic [7:0] mode_b;
		logic [7:0] fmt;
		logic [1:0] pulse_en;
		logic [1:0] pulse_flags;
		logic en_a;
		logic [4:0] en_b;
		logic [5:0] flags_a;
		logic [4:0] flags_b;
		logic force_prev;
		logic [2:0] good_cnt;
		logic [5:0] hist;
		logic [8:0] crc_cnt;
		logic [24:0] sec_cnt;
		logic [1:0][11:0] phase;
		logic [1:0] pulse_seen;
		logic frame_proc_en;
		logic oos;
		logic irq;
		logic waitrequest;
		logic [31:0] readdata;
		logic [1:0] response;
	} state_t;

endpackage

`default_nettype wire

/* File: verilog/t1_rx_sync_ctrl.sv */
/*
 * receive frame synchroniser control and status for one t1/j1 link:
 * bypass, reframe policy, sync acquisition, sliding-window loss,
 * excessive crc-6 counter, flag registers and the interrupt output.
 * assumes a 25 mhz clock, synchronous inputs, an avalon-mm master on the
 * register port and a framing comparator delivering frame_ev_t pulses.
 */
`timescale 1ns/1ps
`default_nettype none
`include "t1_sync_map.svh"

module t1_rx_sync_ctrl #(
	parameter int unsigned SECOND_CYCLES = `CRC_WINDOW_NS / `CLOCK_PERIOD_NS
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// avalon-mm register slave
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic [1:0] response,
	// framing comparator events
	input wire t1_sync_pkg::frame_ev_t ev,
	// system frame pulses
	input wire logic rx_frame_pulse,
	input wire logic tx_frame_pulse,
	// status and control outputs
	output logic frame_proc_en,
	output logic out_of_sync,
	output logic irq
);

	// ****************************************************************
	// constants
	// ****************************************************************
	localparam int unsigned PULSE_CYCLES = `PULSE_GRID_NS / `CLOCK_PERIOD_NS;
	localparam logic [11:0] PHASE_LAST = 12'(PULSE_CYCLES - 1);
	localparam logic [24:0] SEC_LAST = 25'(SECOND_CYCLES - 1);

	t1_sync_pkg::state_t s_q; // registered state
	t1_sync_pkg::state_t s_d; // next state

	// ****************************************************************
	// decoded configuration
	// ****************************************************************
	logic [1:0] fmt; // line format
	logic is_esf; // esf selected
	logic bypass; // unframed mode
	logic req; // bus request present
	logic take; // request completes this edge
	logic [7:0] idx; // register index
	logic wr_ok; // write reaches lane 0
	logic [7:0] wbyte; // written byte
	logic unit_v; // loss window unit present
	logic unit_e; // loss window unit erroneous
	logic [2:0] win; // selected window length
	logic [2:0] errs; // errors in window
	logic acquire; // sync criteria met
	logic lose; // loss threshold reached
	logic crc_reframe; // excessive crc forces search
	logic forced; // rising edge of forced reframe
	logic crc_excess_ev; // count just went past the limit
	logic [1:0] pulse_bad; // off-grid pulse events
	logic [7:0] rd; // read mux
	logic hit; // mapped index

	assign fmt = s_q.fmt[`B_FMT_HI:`B_FMT_LO];
	assign is_esf = (fmt == `FMT_ESF);
	assign bypass = s_q.mode_a[`B_UNFRAMED];
	assign req = read | write;
	assign take = req & ~s_q.waitrequest;
	assign idx = address[9:2];
	assign wr_ok = write & take & byteenable[0] & (address[1:0] == 2'h0);
	assign wbyte = writedata[7:0];

	// ****************************************************************
	// read decode
	// ****************************************************************
	always_comb begin
		rd = `RST_ZERO;
		hit = 1'b1;
		case (idx)
			`IDX_PULSE_FLAGS: rd = {6'h00, s_q.pulse_flags};
			`IDX_PULSE_EN: rd = {6'h00, s_q.pulse_en};
			`IDX_MODE_A: rd = {4'h0, s_q.mode_a[3:0]};
			`IDX_MODE_B: rd = {4'h0, s_q.mode_b[3:0]};
			`IDX_SYNC_STATE: rd = {7'h00, s_q.oos};
			`IDX_IRQ_EN_A: rd = {7'h00, s_q.en_a};
			`IDX_IRQ_EN_B: rd = {3'h0, s_q.en_b};
			`IDX_FLAGS_A: rd = {2'h0, s_q.flags_a};
			`IDX_FLAGS_B: rd = {3'h0, s_q.flags_b};
			`IDX_FORMAT: rd = {5'h00, s_q.fmt[2:0]};
			default: hit = 1'b0;
		endcase
		if (address[1:0] != 2'h0) begin
			hit = 1'b0;
		end
	end

	// ****************************************************************
	// loss window unit and threshold
	// ****************************************************************
	always_comb begin
		// slc-96 picks ft or qualifying fs bits
		if (fmt == `FMT_SLC && s_q.fmt[`B_SLC_FS]) begin
			unit_v = ev.fs_valid;
			unit_e = ev.fs_err;
		end else begin
			unit_v = ev.ft_valid;
			unit_e = ev.ft_err;
		end
		case (s_q.mode_b[`B_LOSS_HI:`B_LOSS_LO])
			2'h0: win = `WIN_4;
			2'h1: win = `WIN_5;
			default: win = `WIN_6;
		endcase
		errs = 3'h0;
		for (int i = 0; i < 6; i++) begin
			if (3'(i) < win && s_q.hist[i]) begin
				errs = errs + 3'h1;
			end
		end
	end

	// newest unit sits in hist[0]; the unit itself is counted this cycle
	assign lose = unit_v && ((errs - {2'h0, s_q.hist[win - 3'h1]} + {2'h0, unit_e})
		>= `LOSS_ERRS);

	// ****************************************************************
	// acquisition criteria
	// ****************************************************************
	always_comb begin
		acquire = 1'b0;
		if (ev.pattern_done && ev.pattern_ok) begin
			case (fmt)
				`FMT_SF: acquire = (s_q.good_cnt + 3'h1 >= `SF_GOOD_NEEDED)
					&& !(s_q.mode_b[`B_MIMIC_CRIT] && ev.mimic);
				`FMT_ESF: acquire = s_q.mode_b[`B_MIMIC_CRIT]
					? ((s_q.good_cnt + 3'h1 >= `ESF_GOOD_NEEDED) && !ev.mimic)
					: ev.crc_ok;
				`FMT_T1DM: acquire = !ev.mimic && (s_q.mode_b[`B_DDS_CRIT]
					? ev.dds_all_ok
					: ev.dds_first_ok);
				default: acquire = (s_q.good_cnt + 3'h1 >= `SF_GOOD_NEEDED);
			endcase
		end
	end

	// reframe causes
	assign forced = s_q.mode_a[`B_FORCE_REFRAME] & ~s_q.force_prev;
	assign crc_excess_ev = is_esf && ev.crc_err && !bypass
		&& (s_q.crc_cnt == `CRC_EXCESS_LIMIT);
	assign crc_reframe = crc_excess_ev && s_q.mode_a[`B_CRC_REFRAME]
		&& s_q.mode_a[`B_AUTO_REFRAME];

	// off-grid frame pulses: phase must wrap to zero exactly at a pulse
	assign pulse_bad[`B_RX_PULSE] = rx_frame_pulse && s_q.pulse_seen[`B_RX_PULSE]
		&& (s_q.phase[`B_RX_PULSE] != 12'h000);
	assign pulse_bad[`B_TX_PULSE] = tx_frame_pulse && s_q.pulse_seen[`B_TX_PULSE]
		&& (s_q.phase[`B_TX_PULSE] != 12'h000);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		s_d = s_q;
		s_d.force_prev = s_q.mode_a[`B_FORCE_REFRAME];

		// bus handshake: one wait state, then one completion cycle
		s_d.waitrequest = !(req && s_q.waitrequest);
		if (req && s_q.waitrequest) begin
			s_d.readdata = read ? {24'h000000, rd} : 32'h00000000;
			s_d.response = hit ? 2'h0 : 2'h2;
		end

		// pulse phase trackers
		for (int k = 0; k < 2; k++) begin
			if ((k == `B_RX_PULSE) ? rx_frame_pulse : tx_frame_pulse) begin
				s_d.phase[k] = 12'h001;
				s_d.pulse_seen[k] = 1'b1;
			end else begin
				s_d.phase[k] = (s_q.phase[k] == PHASE_LAST) ? 12'h000
					: s_q.phase[k] + 12'h001;
			end
		end

		// one second crc window
		if (s_q.sec_cnt == SEC_LAST) begin
			s_d.sec_cnt = 25'h0000000;
			s_d.crc_cnt = 9'h000;
		end else begin
			s_d.sec_cnt = s_q.sec_cnt + 25'h0000001;
			if (is_esf && ev.crc_err && !bypass && s_q.crc_cnt != 9'h1ff) begin
				s_d.crc_cnt = s_q.crc_cnt + 9'h001;
			end
		end

		// sync state machine, frozen while bypassed except that a forced reframe still returns it to search
		if (!bypass) begin
			case (s_q.st)
				t1_sync_pkg::ST_SEARCH: begin
					if (ev.pattern_done) begin
						s_d.good_cnt = ev.pattern_ok ? s_q.good_cnt + 3'h1 : 3'h0;
					end
					if (acquire && !forced) begin
						s_d.st = t1_sync_pkg::ST_INSYNC;
						s_d.hist = 6'h00;
						s_d.good_cnt = 3'h0;
					end
				end
				t1_sync_pkg::ST_INSYNC: begin
					if (unit_v) begin
						s_d.hist = {s_q.hist[4:0], unit_e};
					end
					if (forced || crc_reframe
						|| (lose && s_q.mode_a[`B_AUTO_REFRAME])) begin
						s_d.st = t1_sync_pkg::ST_SEARCH;
						s_d.good_cnt = 3'h0;
					end
				end
				default: s_d.st = t1_sync_pkg::ST_SEARCH;
			endcase
		end else if (forced) begin
			s_d.st = t1_sync_pkg::ST_SEARCH;
		end
		s_d.oos = (s_d.st != t1_sync_pkg::ST_INSYNC);
		s_d.frame_proc_en = !s_d.mode_a[`B_UNFRAMED];

		// register writes and write-one-to-clear
		if (wr_ok) begin
			case (idx)
				`IDX_PULSE_FLAGS: s_d.pulse_flags = s_q.pulse_flags & ~wbyte[1:0];
				`IDX_PULSE_EN: s_d.pulse_en = wbyte[1:0];
				`IDX_MODE_A: s_d.mode_a = {4'h0, wbyte[3:0]};
				`IDX_MODE_B: s_d.mode_b = {4'h0, wbyte[3:0]};
				`IDX_IRQ_EN_A: s_d.en_a = wbyte[0];
				`IDX_IRQ_EN_B: s_d.en_b = wbyte[4:0];
				`IDX_FLAGS_A: s_d.flags_a = s_q.flags_a
					& ~{wbyte[`B_CRC_EXCESS], wbyte[`B_MIMIC_SEEN], 3'h0,
					wbyte[`B_SYNC_CHANGE]};
				`IDX_FLAGS_B: s_d.flags_b = s_q.flags_b & ~wbyte[4:0];
				`IDX_FORMAT: s_d.fmt = {5'h00, wbyte[2:0]};
				default: s_d.fmt = s_q.fmt;
			endcase
		end

		// hardware sets win over software clears
		s_d.pulse_flags = s_d.pulse_flags | pulse_bad;
		if (s_d.oos != s_q.oos) begin
			s_d.flags_a[`B_SYNC_CHANGE] = 1'b1;
		end
		if (crc_excess_ev) begin
			s_d.flags_a[`B_CRC_EXCESS] = 1'b1;
		end
		if (!bypass && ev.mimic && ev.pattern_done
			&& (fmt == `FMT_SF || fmt == `FMT_ESF)) begin
			s_d.flags_a[`B_MIMIC_SEEN] = 1'b1;
		end
		if (!bypass) begin
			s_d.flags_b = s_d.flags_b | {ev.mf_start && !s_q.oos, ev.severe_err,
				ev.crc_err && is_esf, unit_v && unit_e, ev.align_move};
		end

		// interrupt: or of every enabled flag
		s_d.irq = |(s_d.pulse_flags & s_d.pulse_en)
			| (s_d.flags_a[`B_SYNC_CHANGE] & s_d.en_a)
			| |(s_d.flags_b & s_d.en_b);
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.st <= t1_sync_pkg::ST_SEARCH;
			s_q.mode_a <= `RST_MODE_A;
			s_q.oos <= 1'b1;
			s_q.frame_proc_en <= 1'b1;
			s_q.waitrequest <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flip-flops
	assign readdata = s_q.readdata;
	assign waitrequest = s_q.waitrequest;
	assign response = s_q.response;
	assign frame_proc_en = s_q.frame_proc_en;
	assign out_of_sync = s_q.oos;
	assign irq = s_q.irq;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	chk_bypass_follows: assert property (
		##1 frame_proc_en == !$past(s_q.mode_a[`B_UNFRAMED]))
		else $error("frame processing enable does not follow unframed bit");
	chk_forced_search: assert property (
		(forced && !bypass) |=> out_of_sync)
		else $error("forced reframe did not restart search");
	chk_locked_frame: assert property (
		(!s_q.oos && !s_q.mode_a[`B_AUTO_REFRAME] && !forced && !bypass)
		|=> !out_of_sync)
		else $error("locked frame lost sync without forced reframe");
	chk_crc_reframe: assert property (
		(crc_reframe && !bypass) |=> out_of_sync && s_q.flags_a[`B_CRC_EXCESS])
		else $error("excessive crc did not reframe");
	chk_sync_change: assert property (
		(out_of_sync != $past(out_of_sync)) |-> s_q.flags_a[`B_SYNC_CHANGE])
		else $error("sync transition did not set change flag");
	chk_oos_status: assert property (
		out_of_sync == (s_q.st == t1_sync_pkg::ST_SEARCH))
		else $error("out-of-sync status disagrees with state");
	// irq and the flags load at the same edge, so compare registered values
	chk_irq_gate: assert property (
		irq == (|(s_q.pulse_flags & s_q.pulse_en)
		|| (s_q.flags_a[`B_SYNC_CHANGE] && s_q.en_a)
		|| |(s_q.flags_b & s_q.en_b)))
		else $error("interrupt differs from enabled flags");
	chk_excess_hold: assert property (
		(s_q.flags_a[`B_CRC_EXCESS] && !(wr_ok && idx == `IDX_FLAGS_A
		&& wbyte[`B_CRC_EXCESS])) |=> s_q.flags_a[`B_CRC_EXCESS])
		else $error("crc excess flag dropped without a clear");
	// loss with automatic reframe must leave sync on the next edge
	chk_loss_search: assert property (
		(lose && !s_q.oos && s_q.mode_a[`B_AUTO_REFRAME] && !bypass)
		|=> out_of_sync)
		else $error("loss threshold reached but sync kept");
	// mimic seen with a pattern in sf or esf always lands in the flag
	chk_mimic_flag: assert property (
		(!bypass && ev.mimic && ev.pattern_done && (fmt == `FMT_SF || fmt == `FMT_ESF))
		|=> s_q.flags_a[`B_MIMIC_SEEN])
		else $error("mimic pattern did not set mimic flag");
	chk_bus_answer: assert property (
		(req && waitrequest) |=> !waitrequest ##1 waitrequest)
		else $error("bus answer not after exactly one wait state");

	cov_acquire: cover property (out_of_sync ##1 !out_of_sync);
	cov_loss: cover property (!out_of_sync && lose ##1 out_of_sync);
	cov_excess: cover property (crc_excess_ev);
	cov_pulse_bad: cover property (|pulse_bad);
	cov_forced: cover property (forced && !s_q.oos);

endmodule // t1_rx_sync_ctrl

`default_nettype wire

/* File: bench/t1_line_model.sv */
/*
 * far-side model: framing comparator events and system frame pulses.
 * assumes its tasks are called by the bench just after a clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module t1_line_model (
	// clock
	input wire logic clock,
	// towards the block
	output var t1_sync_pkg::frame_ev_t ev,
	output var logic rx_frame_pulse,
	output var logic tx_frame_pulse
);
	// idle levels: strobes low
	initial begin
		ev = '0;
		rx_frame_pulse = 1'b0;
		tx_frame_pulse = 1'b0;
	end

	// hold one event word for n cycles, then back to idle
	task automatic fire(input t1_sync_pkg::frame_ev_t e, input int n);
		@(posedge clock);
		ev <= e;
		repeat (n) @(posedge clock);
		ev <= '0;
	endtask

	// one-cycle pulse on each selected frame line
	task automatic frame(input logic rx, input logic tx);
		@(posedge clock);
		rx_frame_pulse <= rx;
		tx_frame_pulse <= tx;
		@(posedge clock);
		rx_frame_pulse <= 1'b0;
		tx_frame_pulse <= 1'b0;
	endtask
endmodule // t1_line_model

`default_nettype wire

/* File: bench/tb_t1_rx_sync_ctrl.sv */
/*
 * self-checking bench of the receive frame synchroniser control block.
 * assumes t1_line_model as far side and a shortened crc second window.
 */
`timescale 1ns/1ps
`default_nettype none
`include "t1_sync_map.svh"

module tb_t1_rx_sync_ctrl;
	// ********************
	// signals
	// ********************
	localparam int unsigned SEC = 1000; // shortened second window
	localparam logic [13:0] GOOD = 14'h0398; // good pattern, crc and dds
	localparam logic [13:0] MIM = 14'h0020; // mimic present
	localparam logic [13:0] FOK = 14'h2000; // framing unit, no error
	localparam logic [13:0] FERR = 14'h3000; // framing unit in error
	localparam logic [13:0] CRCE = 14'h0040; // crc-6 error event
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [9:0] address = 10'h000;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h00000000;
	logic [3:0] byteenable = 4'h1;
	logic [31:0] readdata;
	logic waitrequest;
	logic [1:0] response;
	t1_sync_pkg::frame_ev_t ev;
	logic rx_frame_pulse;
	logic tx_frame_pulse;
	logic frame_proc_en;
	logic out_of_sync;
	logic irq;
	int num_errors = 0;
	int n_tests = 0;
	logic [31:0] rd; // last read data
	logic [1:0] rs; // last response

	// 25 mhz clock
	always #20 clock = ~clock;

	t1_rx_sync_ctrl #(.SECOND_CYCLES(SEC)) uut (.clock(clock), .nrst(nrst), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .response(response), .ev(ev),
		.rx_frame_pulse(rx_frame_pulse), .tx_frame_pulse(tx_frame_pulse),
		.frame_proc_en(frame_proc_en), .out_of_sync(out_of_sync), .irq(irq));

	t1_line_model far (.clock(clock), .ev(ev), .rx_frame_pulse(rx_frame_pulse),
		.tx_frame_pulse(tx_frame_pulse));

	// ********************
	// shared tasks
	// ********************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one avalon transfer, held until waitrequest is sampled low
	task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clock);
		address <= {idx, 2'b00};
		read <= ~wr;
		write <= wr;
		writedata <= {24'h000000, d};
		// no cycle limit here: a hang is caught by the watchdog
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		rd = readdata;
		rs = response;
		read <= 1'b0;
		write <= 1'b0;
		if (wr) check("write answer data", rd, 32'h0);
	endtask

	task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
		acc(1'b0, idx, 8'h00);
		check(what, rd, {24'h000000, exp});
		check("response", {30'h0, rs}, 32'h0);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// forced reframe: rising edge of the force bit
	task automatic reframe();
		acc(1'b1, `IDX_MODE_A, 8'h07);
		acc(1'b1, `IDX_MODE_A, 8'h06);
		wt(3);
	endtask

	// ********************
	// scenarios
	// ********************
	task automatic t_regs();
		rdc("mode a", `IDX_MODE_A, `RST_MODE_A);
		rdc("mode b", `IDX_MODE_B, `RST_ZERO);
		rdc("sync state", `IDX_SYNC_STATE, 8'h01);
		rdc("irq en a", `IDX_IRQ_EN_A, `RST_ZERO);
		rdc("irq en b", `IDX_IRQ_EN_B, `RST_ZERO);
		rdc("flags a", `IDX_FLAGS_A, `RST_ZERO);
		acc(1'b1, `IDX_SYNC_STATE, 8'hff);
		rdc("read only", `IDX_SYNC_STATE, 8'h01);
		acc(1'b1, `IDX_MODE_B, 8'h0f);
		rdc("mode b rw", `IDX_MODE_B, 8'h0f);
		// a write without lane 0 enabled stores nothing
		byteenable <= 4'h0;
		acc(1'b1, `IDX_MODE_B, 8'h00);
		byteenable <= 4'h1;
		rdc("mode b lane", `IDX_MODE_B, 8'h0f);
		acc(1'b0, 8'h54, 8'h00);
		check("unmapped", {rs, rd[29:0]}, 32'h80000000);
		check("irq idle", 32'(irq), 32'h0);
		$display("test regs done");
	endtask

	task automatic t_events();
		logic [13:0] evs [5] = '{14'h0001, FERR, CRCE, 14'h0002, 14'h0004};
		acc(1'b1, `IDX_MODE_B, 8'h00);
		far.fire(GOOD, 2);
		wt(2);
		check("sync sf", 32'(out_of_sync), 32'h0);
		// crc-6 error flag is only raised in esf
		acc(1'b1, `IDX_FORMAT, {6'h0, `FMT_ESF});
		for (int i = 0; i < 5; i++) begin
			acc(1'b1, `IDX_IRQ_EN_B, 8'h00);
			far.fire(evs[i], 1);
			wt(2);
			check("masked", 32'(irq), 32'h0);
			rdc("event flag", `IDX_FLAGS_B, 8'(1 << i));
			acc(1'b1, `IDX_IRQ_EN_B, 8'(1 << i));
			wt(1);
			check("enabled", 32'(irq), 32'h1);
			acc(1'b1, `IDX_FLAGS_B, 8'(1 << i));
			wt(1);
			check("cleared", 32'(irq), 32'h0);
		end
		acc(1'b1, `IDX_FORMAT, {6'h0, `FMT_SF});
		$display("test events done");
	endtask

	task automatic t_sf();
		int n;
		reframe();
		acc(1'b1, `IDX_MODE_B, 8'h04);
		far.fire(GOOD | MIM, 2);
		wt(2);
		check("mimic blocks", 32'(out_of_sync), 32'h1);
		rdc("mimic seen", `IDX_FLAGS_A, 8'h11);
		acc(1'b1, `IDX_FLAGS_A, 8'h11);
		for (int c = 0; c < 3; c++) begin
			n = 4 + c;
			acc(1'b1, `IDX_MODE_B, 8'(c));
			acc(1'b1, `IDX_IRQ_EN_A, 8'(c != 1));
			far.fire(GOOD | MIM, 2);
			wt(2);
			check("sync", 32'(out_of_sync), 32'h0);
			check("irq gate", 32'(irq), 32'(c != 1));
			acc(1'b1, `IDX_FLAGS_A, 8'h11);
			wt(1);
			check("irq drop", 32'(irq), 32'h0);
			far.fire(FERR, 1);
			repeat (n - 1) far.fire(FOK, 1);
			far.fire(FERR, 1);
			wt(2);
			check("wide gap", 32'(out_of_sync), 32'h0);
			repeat (n - 2) far.fire(FOK, 1);
			far.fire(FERR, 1);
			wt(2);
			check("loss", 32'(out_of_sync), 32'h1);
			rdc("change flag", `IDX_FLAGS_A, 8'h01);
			acc(1'b1, `IDX_FLAGS_A, 8'h11);
		end
		$display("test sf done");
	endtask

	task automatic t_lock();
		acc(1'b1, `IDX_MODE_A, 8'h04);
		far.fire(GOOD, 2);
		wt(2);
		repeat (3) far.fire(FERR, 1);
		wt(2);
		check("locked", 32'(out_of_sync), 32'h0);
		acc(1'b1, `IDX_MODE_A, 8'h05);
		wt(3);
		check("forced", 32'(out_of_sync), 32'h1);
		far.fire(GOOD, 2);
		acc(1'b1, `IDX_MODE_A, 8'h05);
		wt(3);
		check("level only", 32'(out_of_sync), 32'h0);
		acc(1'b1, `IDX_MODE_A, 8'h06);
		$display("test lock done");
	endtask

	task automatic t_dm();
		acc(1'b1, `IDX_FORMAT, {6'h0, `FMT_T1DM});
		acc(1'b1, `IDX_MODE_B, 8'h08);
		reframe();
		far.fire(GOOD & ~14'h0008, 1);
		wt(2);
		check("dds one", 32'(out_of_sync), 32'h1);
		far.fire(GOOD, 1);
		wt(2);
		check("dds all", 32'(out_of_sync), 32'h0);
		acc(1'b1, `IDX_MODE_B, 8'h00);
		reframe();
		far.fire(GOOD | MIM, 1);
		wt(2);
		check("dm mimic", 32'(out_of_sync), 32'h1);
		far.fire(GOOD & ~14'h0008, 1);
		wt(2);
		check("dds first", 32'(out_of_sync), 32'h0);
		$display("test dm done");
	endtask

	task automatic t_esf();
		acc(1'b1, `IDX_FORMAT, {6'h0, `FMT_ESF});
		acc(1'b1, `IDX_MODE_B, 8'h04);
		reframe();
		far.fire(GOOD, 3);
		wt(2);
		check("three", 32'(out_of_sync), 32'h1);
		far.fire(GOOD, 1);
		wt(2);
		check("four", 32'(out_of_sync), 32'h0);
		acc(1'b1, `IDX_MODE_B, 8'h00);
		reframe();
		far.fire(GOOD, 1);
		wt(SEC + 5);
		check("pattern crc", 32'(out_of_sync), 32'h0);
		acc(1'b1, `IDX_FLAGS_A, 8'h3f);
		far.fire(CRCE, 319);
		wt(2);
		rdc("below limit", `IDX_FLAGS_A, 8'h00);
		wt(SEC + 5);
		far.fire(CRCE, 640);
		wt(3);
		check("crc reframe", 32'(out_of_sync), 32'h1);
		rdc("excess", `IDX_FLAGS_A, 8'h21);
		acc(1'b1, `IDX_FLAGS_A, 8'h00);
		rdc("kept", `IDX_FLAGS_A, 8'h21);
		acc(1'b1, `IDX_FLAGS_A, 8'h20);
		rdc("w1c", `IDX_FLAGS_A, 8'h01);
		$display("test esf done");
	endtask

	task automatic t_pulse();
		// sync change flag is still set from earlier tests
		acc(1'b1, `IDX_IRQ_EN_A, 8'h00);
		acc(1'b1, `IDX_PULSE_EN, 8'h02);
		far.frame(1'b1, 1'b1);
		wt(3123);
		far.frame(1'b1, 1'b1);
		wt(2);
		check("on grid", 32'(irq), 32'h0);
		wt(996);
		far.frame(1'b1, 1'b1);
		wt(2);
		check("off grid", 32'(irq), 32'h1);
		rdc("pulse flags", `IDX_PULSE_FLAGS, 8'h03);
		acc(1'b1, `IDX_PULSE_FLAGS, 8'h02);
		wt(1);
		check("tx masked", 32'(irq), 32'h0);
		acc(1'b1, `IDX_PULSE_EN, 8'h01);
		wt(1);
		check("tx enabled", 32'(irq), 32'h1);
		acc(1'b1, `IDX_PULSE_FLAGS, 8'h01);
		wt(1);
		check("tx cleared", 32'(irq), 32'h0);
		$display("test pulse done");
	endtask

	// slc-96 with the fs window: ft errors ignored, fs errors count
	task automatic t_slc();
		acc(1'b1, `IDX_FORMAT, 8'h07);
		far.fire(GOOD, 2);
		wt(2);
		check("slc sync", 32'(out_of_sync), 32'h0);
		repeat (2) far.fire(FERR, 1);
		wt(2);
		check("ft ignored", 32'(out_of_sync), 32'h0);
		repeat (2) far.fire(14'h0c00, 1);
		wt(2);
		check("fs loss", 32'(out_of_sync), 32'h1);
		$display("test slc done");
	endtask

	task automatic t_unf();
		acc(1'b1, `IDX_MODE_A, 8'h0e);
		wt(2);
		check("bypass", 32'(frame_proc_en), 32'h0);
		acc(1'b1, `IDX_MODE_A, 8'h06);
		wt(2);
		check("framed", 32'(frame_proc_en), 32'h1);
		$display("test unframed done");
	endtask

	// ********************
	// sequence and verdict
	// ********************
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// reset for 8 cycles, then the scenarios
	initial begin
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		t_regs();
		t_events();
		t_sf();
		t_lock();
		t_dm();
		t_esf();
		t_pulse();
		t_slc();
		t_unf();
		end_sim();
	end

	// watchdog, well above the expected run
	initial begin
		#(40 * 40000);
		num_errors++;
		end_sim();
	end
endmodule // tb_t1_rx_sync_ctrl

`default_nettype wire
